// [hw/wdr_pkg.sv]
// Constants shared by the watchdog and reset-cause block.
package wdr_pkg;
  // ****************************************
  // Register map (byte addresses on APB)
  // ****************************************
  localparam logic [7:0] ADDR_CAUSE   = 8'h00;
  localparam logic [7:0] ADDR_CTRL    = 8'h04;
  localparam logic [7:0] ADDR_RESTART = 8'h08;
  localparam logic [7:0] ADDR_IRQ_ST  = 8'h0c;
  localparam logic [7:0] ADDR_IRQ_MSK = 8'h10;

  // ****************************************
  // Field layout
  // ****************************************
  localparam int FLAG_W       = 5;
  localparam int BIT_POR      = 0;
  localparam int BIT_PIN      = 1;
  localparam int BIT_BOD      = 2;
  localparam int BIT_WDOG     = 3;
  localparam int BIT_TEST     = 4;
  localparam int SEL_W        = 3;
  localparam int SEL_LSB      = 0;
  localparam int BIT_ENABLE   = 3;
  localparam int BIT_TURN_OFF = 4;
  localparam int RSVD_MSB     = 7;
  localparam int RSVD_LSB     = 5;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [FLAG_W-1:0] CAUSE_RESET = 5'h01;
  localparam logic [FLAG_W-1:0] FLAGS_CLEAR = 5'h00;
  localparam logic [SEL_W-1:0]  SEL_RESET   = 3'h0;
  localparam logic [31:0]       DATA_ZERO   = 32'h0000_0000;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_HZ         = 25_000_000;
  localparam int OSC_HZ         = 1_000_000;
  localparam int TICK_DIV       = CLK_HZ / OSC_HZ;
  localparam int DIV_W          = 5;
  localparam int TURN_OFF_CYC   = 4;
  localparam int TOE_W          = 3;
  localparam int BASE_TIMEOUT   = 16_384;
  localparam int CNT_W          = 22;
endpackage

// [hw/wdr_wdog_counter.sv]
// Watchdog period counter, advanced by the oscillator-rate enable.
`timescale 1ns/1ps
module wdr_wdog_counter #(
  parameter int BASE_TIMEOUT = wdr_pkg::BASE_TIMEOUT
) (
  input  wire logic                     clk,        // main clock
  input  wire logic                     rst,        // async reset, high
  input  wire logic                     oscTick,    // oscillator-rate enable
  input  wire logic                     clear,      // restart from zero
  input  wire logic                     run,        // watchdog enabled
  input  wire logic [wdr_pkg::SEL_W-1:0] timeoutSel, // period code
  output logic                          expire,     // one-cycle timeout pulse
  output logic [wdr_pkg::CNT_W-1:0]     count       // current count
);
  logic [wdr_pkg::CNT_W-1:0] limit;
  logic                      atLimit;

  // Each code step doubles the period.
  assign limit   = wdr_pkg::CNT_W'(BASE_TIMEOUT) << timeoutSel;
  assign atLimit = (count == limit - wdr_pkg::CNT_W'(1));

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count <= '0;
    end else if (clear || !run) begin
      count <= '0;
    end else if (oscTick) begin
      count <= atLimit ? '0 : count + wdr_pkg::CNT_W'(1);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      expire <= 1'b0;
    end else begin
      expire <= run && !clear && oscTick && atLimit;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  restart_zero_a: assert property (clear |=> count == '0)
    else $error("count not zero after restart");
  period_end_a: assert property (expire |-> $past(count) == limit - wdr_pkg::CNT_W'(1))
    else $error("timeout fired before selected period");
  idle_hold_a: assert property (!run |=> count == '0 && !expire)
    else $error("disabled watchdog still counting");
endmodule

// [hw/wdr_top.sv]
// Watchdog timer with guarded turn-off and reset-cause flags on APB.
`timescale 1ns/1ps
module wdr_top #(
  parameter int BASE_TIMEOUT = wdr_pkg::BASE_TIMEOUT
) (
  input  wire logic        ref_clk,      // 25 MHz main clock
  input  wire logic        rst,          // power-on reset, async, high
  input  wire logic        psel,         // APB select
  input  wire logic        penable,      // APB access phase
  input  wire logic        pwrite,       // APB write
  input  wire logic [7:0]  paddr,        // APB byte address
  input  wire logic [31:0] pwdata,       // APB write data
  output logic [31:0]      prdata,       // APB read data
  output logic             pready,       // APB ready
  output logic             pslverr,      // APB error on unmapped address
  input  wire logic        pinResetIn,   // external pin reset active
  input  wire logic        brownoutIn,   // brown-out reset active
  input  wire logic        testResetIn,  // test-port reset register holds one
  output logic             wdtResetOut,  // one-cycle watchdog reset pulse
  output logic             watchdogOn,   // watchdog enabled
  output logic             irq           // level interrupt
);
  // ****************************************
  // Declarations
  // ****************************************
  logic [wdr_pkg::FLAG_W-1:0]  cause;
  logic [wdr_pkg::FLAG_W-1:0]  causeSet;
  logic [wdr_pkg::FLAG_W-1:0]  causeClr;
  logic [wdr_pkg::FLAG_W-1:0]  irqStatus;
  logic [wdr_pkg::FLAG_W-1:0]  irqMask;
  logic [wdr_pkg::FLAG_W-1:0]  irqEvent;
  logic [wdr_pkg::FLAG_W-1:0]  irqClr;
  logic [wdr_pkg::SEL_W-1:0]   timeoutSel;
  logic [wdr_pkg::TOE_W-1:0]   toeCount;
  logic [wdr_pkg::DIV_W-1:0]   divCount;
  logic [wdr_pkg::CNT_W-1:0]   wdCount;
  logic [31:0]                 next_prdata;
  logic                        wdEnable;
  logic                        turnOffEnable;
  logic                        restartReq;
  logic                        oscTick;
  logic                        chipReset;
  logic                        pinPrev;
  logic                        bodPrev;
  logic                        testPrev;
  logic                        setupPhase;
  logic                        wrAccess;
  logic                        hitCause;
  logic                        hitCtrl;
  logic                        hitRestart;
  logic                        hitIrqSt;
  logic                        hitIrqMsk;
  logic                        mapped;
  logic                        wrCause;
  logic                        wrCtrl;
  logic                        wrRestart;
  logic                        wrIrqSt;
  logic                        wrIrqMsk;

  // ****************************************
  // APB decode
  // ****************************************
  // Registers answer with no wait states; read data is captured in the
  // setup cycle so that prdata always comes from a flip-flop.
  assign setupPhase = psel && !penable;
  assign wrAccess   = psel && penable && pwrite;
  assign hitCause   = (paddr == wdr_pkg::ADDR_CAUSE);
  assign hitCtrl    = (paddr == wdr_pkg::ADDR_CTRL);
  assign hitRestart = (paddr == wdr_pkg::ADDR_RESTART);
  assign hitIrqSt   = (paddr == wdr_pkg::ADDR_IRQ_ST);
  assign hitIrqMsk  = (paddr == wdr_pkg::ADDR_IRQ_MSK);
  assign mapped     = hitCause || hitCtrl || hitRestart || hitIrqSt || hitIrqMsk;
  assign wrCause    = wrAccess && hitCause;
  assign wrCtrl     = wrAccess && hitCtrl;
  assign wrRestart  = wrAccess && hitRestart;
  assign wrIrqSt    = wrAccess && hitIrqSt;
  assign wrIrqMsk   = wrAccess && hitIrqMsk;
  assign pready     = 1'b1;
  assign pslverr    = psel && penable && !mapped;

  always_comb begin
    next_prdata = wdr_pkg::DATA_ZERO;
    if (hitCause) begin
      next_prdata[wdr_pkg::FLAG_W-1:0] = cause;
    end else if (hitCtrl) begin
      // Upper control bits are left at zero.
      next_prdata[wdr_pkg::RSVD_MSB:wdr_pkg::RSVD_LSB] = '0;
      next_prdata[wdr_pkg::BIT_TURN_OFF]                = turnOffEnable;
      next_prdata[wdr_pkg::BIT_ENABLE]                  = wdEnable;
      next_prdata[wdr_pkg::SEL_LSB +: wdr_pkg::SEL_W]   = timeoutSel;
    end else if (hitIrqSt) begin
      next_prdata[wdr_pkg::FLAG_W-1:0] = irqStatus;
    end else if (hitIrqMsk) begin
      next_prdata[wdr_pkg::FLAG_W-1:0] = irqMask;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      prdata <= wdr_pkg::DATA_ZERO;
    end else if (setupPhase) begin
      prdata <= pwrite ? wdr_pkg::DATA_ZERO : next_prdata;
    end
  end

  // ****************************************
  // Reset sources
  // ****************************************
  // Any chip reset other than power-on; rst itself is the power-on reset.
  assign chipReset = pinResetIn || brownoutIn || testResetIn || wdtResetOut;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pinPrev  <= 1'b0;
      bodPrev  <= 1'b0;
      testPrev <= 1'b0;
    end else begin
      pinPrev  <= pinResetIn;
      bodPrev  <= brownoutIn;
      testPrev <= testResetIn;
    end
  end

  // ****************************************
  // Reset-cause flags
  // ****************************************
  // Flags set while their source is active; a set in the same cycle as a
  // write of zero wins, so no reset can go unrecorded.
  always_comb begin
    causeSet                   = '0;
    causeSet[wdr_pkg::BIT_PIN]  = pinResetIn;
    causeSet[wdr_pkg::BIT_BOD]  = brownoutIn;
    causeSet[wdr_pkg::BIT_WDOG] = wdtResetOut;
    causeSet[wdr_pkg::BIT_TEST] = testResetIn;
  end

  assign causeClr = wrCause ? ~pwdata[wdr_pkg::FLAG_W-1:0] : '0;

  genvar gi;
  generate
    for (gi = 0; gi < wdr_pkg::FLAG_W; gi++) begin : g_flag
      always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
          cause[gi] <= wdr_pkg::CAUSE_RESET[gi];
        end else begin
          cause[gi] <= causeSet[gi] || (cause[gi] && !causeClr[gi]);
        end
      end
    end
  endgenerate

  // ****************************************
  // Watchdog control register
  // ****************************************
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      timeoutSel <= wdr_pkg::SEL_RESET;
    end else if (chipReset) begin
      timeoutSel <= wdr_pkg::SEL_RESET;
    end else if (wrCtrl) begin
      // The period code takes even a write whose disable is refused.
      timeoutSel <= pwdata[wdr_pkg::SEL_LSB +: wdr_pkg::SEL_W];
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wdEnable <= 1'b0;
    end else if (chipReset) begin
      wdEnable <= 1'b0;
    end else if (wrCtrl) begin
      if (pwdata[wdr_pkg::BIT_ENABLE]) begin
        wdEnable <= 1'b1;
      end else if (turnOffEnable) begin
        wdEnable <= 1'b0;
      end
    end
  end

  // Writing zero to the turn-off bit has no effect; only time or a chip reset clears it.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      turnOffEnable <= 1'b0;
      toeCount      <= '0;
    end else if (chipReset) begin
      turnOffEnable <= 1'b0;
      toeCount      <= '0;
    end else if (wrCtrl && pwdata[wdr_pkg::BIT_TURN_OFF]) begin
      turnOffEnable <= 1'b1;
      toeCount      <= wdr_pkg::TOE_W'(wdr_pkg::TURN_OFF_CYC);
    end else if (toeCount != '0) begin
      toeCount <= toeCount - wdr_pkg::TOE_W'(1);
      if (toeCount == wdr_pkg::TOE_W'(1)) begin
        turnOffEnable <= 1'b0;
      end
    end
  end

  assign watchdogOn = wdEnable;

  // ****************************************
  // Oscillator-rate enable and restart
  // ****************************************
  // The watchdog rate is an enable from this divider, so restart and
  // timeout stay in one clock domain and need no synchroniser.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      divCount <= '0;
      oscTick  <= 1'b0;
    end else if (divCount == wdr_pkg::DIV_W'(wdr_pkg::TICK_DIV - 1)) begin
      divCount <= '0;
      oscTick  <= 1'b1;
    end else begin
      divCount <= divCount + wdr_pkg::DIV_W'(1);
      oscTick  <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      restartReq <= 1'b0;
    end else begin
      restartReq <= wrRestart;
    end
  end

  wdr_wdog_counter #(
    .BASE_TIMEOUT(BASE_TIMEOUT)
  ) u_counter (
    .clk        (ref_clk),
    .rst        (rst),
    .oscTick    (oscTick),
    .clear      (restartReq || chipReset),
    .run        (wdEnable),
    .timeoutSel (timeoutSel),
    .expire     (wdtResetOut),
    .count      (wdCount)
  );

  // ****************************************
  // Interrupts
  // ****************************************
  always_comb begin
    irqEvent                    = '0;
    irqEvent[wdr_pkg::BIT_PIN]  = pinResetIn && !pinPrev;
    irqEvent[wdr_pkg::BIT_BOD]  = brownoutIn && !bodPrev;
    irqEvent[wdr_pkg::BIT_WDOG] = wdtResetOut;
    irqEvent[wdr_pkg::BIT_TEST] = testResetIn && !testPrev;
  end

  assign irqClr = wrIrqSt ? pwdata[wdr_pkg::FLAG_W-1:0] : '0;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      irqStatus <= wdr_pkg::FLAGS_CLEAR;
    end else begin
      irqStatus <= irqEvent | (irqStatus & ~irqClr);
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      irqMask <= wdr_pkg::FLAGS_CLEAR;
    end else if (wrIrqMsk) begin
      irqMask <= pwdata[wdr_pkg::FLAG_W-1:0];
    end
  end

  assign irq = |(irqStatus & irqMask);

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  test_flag_set_a: assert property (testResetIn |=> cause[wdr_pkg::BIT_TEST])
    else $error("test-port reset flag not set");
  wdog_flag_set_a: assert property (wdtResetOut |=> cause[wdr_pkg::BIT_WDOG])
    else $error("watchdog reset flag not set");
  bod_flag_set_a: assert property (brownoutIn |=> cause[wdr_pkg::BIT_BOD])
    else $error("brown-out flag not set");
  pin_flag_set_a: assert property (pinResetIn |=> cause[wdr_pkg::BIT_PIN])
    else $error("pin reset flag not set");
  por_flag_hold_a: assert property (
    cause[wdr_pkg::BIT_POR] && !(wrCause && !pwdata[wdr_pkg::BIT_POR]) |=> cause[wdr_pkg::BIT_POR])
    else $error("power-on flag lost without software clear");
  ctrl_rsvd_zero_a: assert property (
    psel && penable && !pwrite && hitCtrl |-> prdata[wdr_pkg::RSVD_MSB:wdr_pkg::RSVD_LSB] == '0)
    else $error("reserved control bits read nonzero");
  toe_window_a: assert property (
    $rose(turnOffEnable) && !chipReset && !(wrCtrl && pwdata[wdr_pkg::BIT_TURN_OFF])
      ##1 (!chipReset && !(wrCtrl && pwdata[wdr_pkg::BIT_TURN_OFF]))[*3]
      |=> !turnOffEnable)
    else $error("turn-off enable not cleared after four cycles");
  toe_hold_a: assert property ($rose(turnOffEnable) && !chipReset |=> turnOffEnable[*3])
    else $error("turn-off enable cleared early");
  enable_guard_a: assert property (
    wrCtrl && !pwdata[wdr_pkg::BIT_ENABLE] && !turnOffEnable && wdEnable && !chipReset |=> wdEnable)
    else $error("watchdog disabled without turn-off window");
  sel_update_a: assert property (
    wrCtrl && !chipReset |=> timeoutSel == $past(pwdata[wdr_pkg::SEL_LSB +: wdr_pkg::SEL_W]))
    else $error("prescaler not updated by control write");
  pulse_single_a: assert property (wdtResetOut |=> !wdtResetOut)
    else $error("watchdog reset pulse longer than one cycle");
  restart_clear_a: assert property (wrRestart |=> ##1 wdCount == '0)
    else $error("restart did not zero the counter");

  disable_seq_c: cover property (
    wrCtrl && pwdata[wdr_pkg::BIT_TURN_OFF] && pwdata[wdr_pkg::BIT_ENABLE] ##[1:4] wrCtrl ##1 !wdEnable);
  timeout_c: cover property (wdEnable ##1 wdtResetOut);
  por_clear_c: cover property (wrCause && !pwdata[wdr_pkg::BIT_POR] ##1 !cause[wdr_pkg::BIT_POR]);
  irq_c: cover property (irq);
endmodule

// [bench/wdr_top_tb_top.sv]
// Self-checking bench for the watchdog and reset-cause block.
`timescale 1ns/1ps
module wdr_top_tb_top;
  // ****************************************
  // Signals
  // ****************************************
  // A short base period keeps all eight timeout codes inside one run.
  localparam int BASE = 4;
  localparam int DIV  = 25;
  logic        refClk = 1'b0;
  logic        rst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        pinResetIn;
  logic        brownoutIn;
  logic        testResetIn;
  logic        wdtResetOut;
  logic        watchdogOn;
  logic        irq;
  logic        lastErr;
  logic [31:0] q;
  int          errorCnt = 0;
  int          nTests   = 0;
  int          pulseCnt = 0;

  wdr_top #(.BASE_TIMEOUT(BASE)) u_dut (
    .ref_clk     (refClk),
    .rst         (rst),
    .psel        (psel),
    .penable     (penable),
    .pwrite      (pwrite),
    .paddr       (paddr),
    .pwdata      (pwdata),
    .prdata      (prdata),
    .pready      (pready),
    .pslverr     (pslverr),
    .pinResetIn  (pinResetIn),
    .brownoutIn  (brownoutIn),
    .testResetIn (testResetIn),
    .wdtResetOut (wdtResetOut),
    .watchdogOn  (watchdogOn),
    .irq         (irq)
  );

  always #20 refClk = ~refClk;

  // Outputs are watched on the falling edge, well away from register updates.
  always @(negedge refClk) begin
    if (wdtResetOut === 1'b1) begin
      pulseCnt++;
    end
  end

  // ****************************************
  // Helpers
  // ****************************************
  task automatic chk_val(input string what, input logic [31:0] exp, input logic [31:0] got);
    nTests++;
    if (got !== exp) begin
      errorCnt++;
      $display("[ERR] %s exp %h got %h", what, exp, got);
    end
  endtask

  task automatic chk_range(input string what, input int lo, input int hi, input int got);
    nTests++;
    if (got < lo || got > hi) begin
      errorCnt++;
      $display("[ERR] %s exp %0d..%0d got %0d", what, lo, hi, got);
    end
  endtask

  // The access phase waits for the slave; only the run time limit below ends a hang.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge refClk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge refClk);
    penable <= 1'b1;
    do begin
      @(posedge refClk);
    end while (pready !== 1'b1);
    q       = prdata;
    lastErr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input string what, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk_val(what, exp, q);
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge refClk);
  endtask

  task automatic pulse_src(input int src);
    @(posedge refClk);
    case (src)
      0: pinResetIn <= 1'b1;
      1: brownoutIn <= 1'b1;
      default: testResetIn <= 1'b1;
    endcase
    @(posedge refClk);
    pinResetIn  <= 1'b0;
    brownoutIn  <= 1'b0;
    testResetIn <= 1'b0;
    idle(2);
  endtask

  task automatic tallyAndFinish();
    $display("comparisons %0d mismatches %0d", nTests, errorCnt);
    if (errorCnt == 0 && nTests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset();
    rd("cause after power-on", wdr_pkg::ADDR_CAUSE, 32'h01);
    rd("control after power-on", wdr_pkg::ADDR_CTRL, 32'h00);
    chk_val("enable after power-on", 1'b0, watchdogOn);
    rd("unmapped read", 8'h14, 32'h00);
    chk_val("unmapped slverr", 1'b1, lastErr);
    $display("test reset done");
  endtask

  task automatic t_cause();
    logic [31:0] bitv [3];
    bitv = '{32'h02, 32'h04, 32'h10};
    wr(wdr_pkg::ADDR_CAUSE, 32'h00);
    rd("power-on flag cleared", wdr_pkg::ADDR_CAUSE, 32'h00);
    for (int i = 0; i < 3; i++) begin
      pulse_src(i);
      rd("flag set", wdr_pkg::ADDR_CAUSE, bitv[i]);
      wr(wdr_pkg::ADDR_CAUSE, 32'h1f);
      rd("flag kept by one", wdr_pkg::ADDR_CAUSE, bitv[i]);
      wr(wdr_pkg::ADDR_CAUSE, 32'h00);
      rd("flag cleared by zero", wdr_pkg::ADDR_CAUSE, 32'h00);
    end
    $display("test cause done");
  endtask

  task automatic t_ctrl();
    wr(wdr_pkg::ADDR_CTRL, 32'hff);
    idle(6);
    rd("reserved and turn-off", wdr_pkg::ADDR_CTRL, 32'h0f);
    wr(wdr_pkg::ADDR_CTRL, 32'h06);
    rd("refused disable", wdr_pkg::ADDR_CTRL, 32'h0e);
    wr(wdr_pkg::ADDR_CTRL, 32'h1f);
    idle(6);
    wr(wdr_pkg::ADDR_CTRL, 32'h07);
    rd("late disable", wdr_pkg::ADDR_CTRL, 32'h0f);
    wr(wdr_pkg::ADDR_CTRL, 32'h1e);
    wr(wdr_pkg::ADDR_CTRL, 32'h05);
    rd("guarded disable", wdr_pkg::ADDR_CTRL, 32'h05);
    chk_val("enable output off", 1'b0, watchdogOn);
    $display("test control done");
  endtask

  task automatic t_timeout();
    int n;
    int per;
    for (int c = 0; c < 8; c++) begin
      per = BASE << c;
      wr(wdr_pkg::ADDR_CAUSE, 32'h00);
      wr(wdr_pkg::ADDR_CTRL, 32'h08 | c);
      wr(wdr_pkg::ADDR_RESTART, 32'h00);
      n = 0;
      do begin
        @(negedge refClk);
        n++;
      end while (wdtResetOut !== 1'b1 && n < per * DIV + 100);
      // The oscillator divider phase is free, so one tick of slack is allowed.
      chk_range("timeout cycles", (per - 1) * DIV, per * DIV + 5, n);
      @(negedge refClk);
      chk_val("pulse width", 1'b0, wdtResetOut);
      rd("watchdog flag", wdr_pkg::ADDR_CAUSE, 32'h08);
      chk_val("off after timeout", 1'b0, watchdogOn);
    end
    // Earlier pin, brown-out and test-port events plus the timeouts stay pending.
    rd("irq status after timeouts", wdr_pkg::ADDR_IRQ_ST, 32'h1e);
    $display("test timeout done");
  endtask

  task automatic t_restart();
    int p0;
    p0 = pulseCnt;
    wr(wdr_pkg::ADDR_CTRL, 32'h08);
    for (int i = 0; i < 12; i++) begin
      wr(wdr_pkg::ADDR_RESTART, 32'h00);
      idle(15);
    end
    chk_val("no timeout while restarted", p0, pulseCnt);
    wr(wdr_pkg::ADDR_CTRL, 32'h18);
    wr(wdr_pkg::ADDR_CTRL, 32'h00);
    idle(300);
    chk_val("no timeout when disabled", p0, pulseCnt);
    $display("test restart done");
  endtask

  task automatic t_irq();
    wr(wdr_pkg::ADDR_IRQ_ST, 32'h1f);
    wr(wdr_pkg::ADDR_IRQ_MSK, 32'h02);
    pulse_src(0);
    chk_val("irq unmasked event", 1'b1, irq);
    pulse_src(1);
    rd("irq status", wdr_pkg::ADDR_IRQ_ST, 32'h06);
    wr(wdr_pkg::ADDR_IRQ_ST, 32'h02);
    @(negedge refClk);
    chk_val("irq masked pending", 1'b0, irq);
    wr(wdr_pkg::ADDR_IRQ_MSK, 32'h04);
    @(negedge refClk);
    chk_val("irq after unmask", 1'b1, irq);
    wr(wdr_pkg::ADDR_IRQ_ST, 32'h04);
    @(negedge refClk);
    chk_val("irq after clear", 1'b0, irq);
    pulse_src(2);
    rd("irq test-port event", wdr_pkg::ADDR_IRQ_ST, 32'h10);
    $display("test irq done");
  endtask

  // ****************************************
  // Sequence and watchdog
  // ****************************************
  initial begin
    rst         = 1'b1;
    psel        = 1'b0;
    penable     = 1'b0;
    pwrite      = 1'b0;
    paddr       = 8'h00;
    pwdata      = 32'h0000_0000;
    pinResetIn  = 1'b0;
    brownoutIn  = 1'b0;
    testResetIn = 1'b0;
    repeat (20) @(posedge refClk);
    rst <= 1'b0;
    t_reset();
    t_cause();
    t_ctrl();
    t_timeout();
    t_restart();
    t_irq();
    tallyAndFinish();
  end

  // The longest code alone needs about 13k cycles; 60k leaves ample margin.
  initial begin
    #2_400_000;
    errorCnt++;
    $display("[ERR] run time limit reached");
    tallyAndFinish();
  end
endmodule
